// ---- pkg/gacp_pkg.sv ----
// constants, types and helpers shared by the command handler
package gacp_pkg;
    // bus command bytes, sent with attention true
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_GET = 8'h08;
    localparam logic [7:0] CMD_LLO = 8'h11;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_UNL = 8'h3f;
    localparam logic [2:0] LAG_TAG = 3'h1;
    // command letters and characters
    localparam logic [7:0] LET_DISP = 8'h44;
    localparam logic [7:0] LET_PROG = 8'h50;
    localparam logic [7:0] LET_TRIG = 8'h54;
    localparam logic [7:0] LET_DWELL = 8'h57;
    localparam logic [7:0] LET_LOC = 8'h42;
    localparam logic [7:0] LET_EXEC = 8'h58;
    localparam logic [7:0] CHR_A = 8'h41;
    localparam logic [7:0] CHR_Z = 8'h5a;
    localparam logic [7:0] CHR_0 = 8'h30;
    localparam logic [7:0] CHR_9 = 8'h39;
    localparam int DEC_BASE = 10;
    // widths and limits
    localparam int DWELL_W = 16;
    localparam int LOC_W = 8;
    localparam logic [DWELL_W-1:0] DISP_MAX = 16'h0004;
    localparam logic [DWELL_W-1:0] PROG_MAX = 16'h0002;
    localparam logic [DWELL_W-1:0] TRIG_MAX = 16'h0007;
    localparam logic [DWELL_W-1:0] LOC_MAX = 16'h00ff;
    // modes and reset values
    localparam logic [1:0] PROG_CYCLE = 2'h1;
    localparam logic [1:0] PROG_CONT = 2'h2;
    localparam logic [2:0] TRIG_START_GET = 3'h2;
    localparam logic [2:0] TRIG_STOP_GET = 3'h3;
    localparam logic [2:0] DISP_DEF = 3'h0;
    localparam logic [1:0] PROG_DEF = 2'h0;
    localparam logic [2:0] TRIG_DEF = 3'h6;
    localparam logic [DWELL_W-1:0] DWELL_DEF = 16'h0000;
    localparam logic [LOC_W-1:0] LOC_FIRST = 8'h01;
    // status word layout
    localparam int STAT_W = 16;
    localparam int ST_DISP_LSB = 0;
    localparam int ST_PROG_LSB = 3;
    localparam int ST_TRIG_LSB = 5;
    localparam int ST_RUN_BIT = 8;
    localparam int ST_REM_BIT = 9;
    localparam int ST_LLO_BIT = 10;
    localparam int ST_ERR_BIT = 11;

    typedef enum logic [1:0] {PS_LETTER = 2'b01, PS_PARAM = 2'b10} gacp_pstate_t;

    typedef struct packed {
        logic err;
        logic d_v;
        logic [2:0] d;
        logic p_v;
        logic [1:0] p;
        logic t_v;
        logic [2:0] t;
        logic w_v;
        logic [DWELL_W-1:0] w;
        logic b_v;
        logic [LOC_W-1:0] b;
    } gacp_pend_t;

    function automatic logic is_upper(input logic [7:0] c);
        return c >= CHR_A && c <= CHR_Z;
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        return c >= CHR_0 && c <= CHR_9;
    endfunction
endpackage

// ---- pkg/gacp_strm_if.sv ----
// byte stream carrier between the command buffer and the parser
`timescale 1ns/1ns
`default_nettype none
interface gacp_strm_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- design/gacp_fifo.sv ----
// command text buffer fifo
`timescale 1ns/1ns
`default_nettype none
module gacp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    gacp_strm_if.src out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = cnt_r != FULL_CNT;
    assign out.valid = cnt_r != '0;
    assign out.data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out.valid && out.ready;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_comb begin
        wp_nxt = push ? bump(wp_r) : wp_r;
        rp_nxt = pop ? bump(rp_r) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        // a flush drops half-typed text along with the device state
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (push && !flush) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- design/gacp_remote.sv ----
// remote, local and lockout tracking
`timescale 1ns/1ns
`default_nettype none
module gacp_remote (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // events
    input wire logic ren,
    input wire logic listen_hit,
    input wire logic gtl_hit,
    input wire logic llo_hit,
    input wire logic local_key,
    // state
    output logic remote,
    output logic lockout
);
    logic rem_r, rem_nxt, llo_r, llo_nxt;

    always_comb begin
        rem_nxt = rem_r;
        llo_nxt = llo_r;
        if (!ren) begin
            rem_nxt = 1'b0;
            llo_nxt = 1'b0;
        end else begin
            if (gtl_hit || local_key) begin
                rem_nxt = 1'b0;
            end else if (listen_hit) begin
                rem_nxt = 1'b1;
            end
            if (llo_hit) begin
                llo_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rem_r <= 1'b0;
            llo_r <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            llo_r <= llo_nxt;
        end
    end

    assign remote = rem_r;
    assign lockout = llo_r;
endmodule
`default_nettype wire

// ---- design/gacp_top.sv ----
// addressed bus command handler and device command string parser
`timescale 1ns/1ns
`default_nettype none
module gacp_top #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bus bytes after the handshake
    input wire logic bus_valid,
    input wire logic bus_atn,
    input wire logic [7:0] bus_data,
    output logic bus_ready,
    // configuration
    input wire logic [4:0] my_addr,
    input wire logic ren,
    // front panel
    input wire logic local_key,
    input wire logic panel_req,
    output logic panel_grant,
    // indicators
    output logic remote_led,
    output logic lockout,
    output logic running_led,
    // settings and status
    output logic [2:0] disp_mode,
    output logic [1:0] prog_mode,
    output logic [2:0] trig_mode,
    output logic [gacp_pkg::DWELL_W-1:0] dwell_time,
    output logic [gacp_pkg::LOC_W-1:0] buf_ptr,
    output logic [gacp_pkg::LOC_W-1:0] disp_ptr,
    output logic mem_clear,
    output logic [gacp_pkg::STAT_W-1:0] status_word
);
    localparam int DW = gacp_pkg::DWELL_W;
    localparam int LW = gacp_pkg::LOC_W;

    logic cmd_take, listen_hit, unl_hit, sdc_cmd, dcl_cmd, get_cmd;
    logic gtl_cmd, llo_cmd, clr, gtl_hit;
    logic listen_r, listen_nxt;
    logic fifo_in_valid, fifo_in_ready, take;

    assign cmd_take = bus_valid && bus_atn;
    assign listen_hit = cmd_take && bus_data[7:5] == gacp_pkg::LAG_TAG && bus_data[4:0] == my_addr;
    assign unl_hit = cmd_take && bus_data == gacp_pkg::CMD_UNL;
    assign sdc_cmd = cmd_take && bus_data == gacp_pkg::CMD_SDC;
    assign dcl_cmd = cmd_take && bus_data == gacp_pkg::CMD_DCL;
    assign get_cmd = cmd_take && bus_data == gacp_pkg::CMD_GET;
    assign gtl_cmd = cmd_take && bus_data == gacp_pkg::CMD_GTL;
    assign llo_cmd = cmd_take && bus_data == gacp_pkg::CMD_LLO;
    // addressed commands only count once we were made listener
    assign clr = dcl_cmd || (sdc_cmd && listen_r);
    assign gtl_hit = gtl_cmd && listen_r;

    always_comb begin
        listen_nxt = listen_r;
        if (unl_hit) begin
            listen_nxt = 1'b0;
        end else if (listen_hit) begin
            listen_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            listen_r <= 1'b0;
        end else begin
            listen_r <= listen_nxt;
        end
    end

    gacp_remote u_remote (
        .mclk(mclk),
        .rst_n(rst_n),
        .ren(ren),
        .listen_hit(listen_hit),
        .gtl_hit(gtl_hit),
        .llo_hit(llo_cmd),
        .local_key(local_key),
        .remote(remote_led),
        .lockout(lockout)
    );
    // lockout outlives go-to-local until remote enable drops
    assign panel_grant = panel_req && !lockout;

    gacp_strm_if #(.W(8)) cbuf ();
    assign fifo_in_valid = bus_valid && !bus_atn && listen_r;
    // unaddressed data is swallowed; the bus only waits on us while we listen and the fifo is full
    assign bus_ready = bus_atn || !listen_r || fifo_in_ready;

    gacp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(clr),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(bus_data),
        .out(cbuf.src)
    );

    // parser
    gacp_pkg::gacp_pstate_t ps_r, ps_nxt;
    logic [7:0] let_r, let_nxt;
    logic [DW-1:0] num_r, num_nxt;
    logic dig_r, dig_nxt, exec_r, exec_nxt;
    gacp_pkg::gacp_pend_t pd_r, pd_nxt;

    // execution takes one cycle, so the buffer is held off meanwhile
    assign cbuf.ready = !exec_r;
    assign take = cbuf.valid && cbuf.ready;

    function automatic gacp_pkg::gacp_pend_t commit(input gacp_pkg::gacp_pend_t p, input logic [7:0] l,
                                                    input logic [DW-1:0] n, input logic d);
        gacp_pkg::gacp_pend_t c;
        c = p;
        if (!d) begin
            c.err = 1'b1;
        end else begin
            case (l)
                gacp_pkg::LET_DISP: begin
                    c.err = c.err || n > gacp_pkg::DISP_MAX;
                    c.d_v = 1'b1;
                    c.d = n[2:0];
                end
                gacp_pkg::LET_PROG: begin
                    c.err = c.err || n > gacp_pkg::PROG_MAX;
                    c.p_v = 1'b1;
                    c.p = n[1:0];
                end
                gacp_pkg::LET_TRIG: begin
                    c.err = c.err || n > gacp_pkg::TRIG_MAX;
                    c.t_v = 1'b1;
                    c.t = n[2:0];
                end
                gacp_pkg::LET_DWELL: begin
                    c.w_v = 1'b1;
                    c.w = n;
                end
                gacp_pkg::LET_LOC: begin
                    c.err = c.err || n == '0 || n > gacp_pkg::LOC_MAX;
                    c.b_v = 1'b1;
                    c.b = n[LW-1:0];
                end
                default: c.err = 1'b1;
            endcase
        end
        return c;
    endfunction

    always_comb begin
        ps_nxt = ps_r;
        let_nxt = let_r;
        num_nxt = num_r;
        dig_nxt = dig_r;
        pd_nxt = pd_r;
        exec_nxt = 1'b0;
        if (clr) begin
            ps_nxt = gacp_pkg::PS_LETTER;
            num_nxt = '0;
            dig_nxt = 1'b0;
            pd_nxt = '0;
        end else if (exec_r) begin
            pd_nxt = '0;
        end else if (take) begin
            if (gacp_pkg::is_upper(cbuf.data)) begin
                if (ps_r == gacp_pkg::PS_PARAM) begin
                    pd_nxt = commit(pd_r, let_r, num_r, dig_r);
                end
                if (cbuf.data == gacp_pkg::LET_EXEC) begin
                    exec_nxt = 1'b1;
                    ps_nxt = gacp_pkg::PS_LETTER;
                end else begin
                    ps_nxt = gacp_pkg::PS_PARAM;
                    let_nxt = cbuf.data;
                    num_nxt = '0;
                    dig_nxt = 1'b0;
                end
            end else if (ps_r == gacp_pkg::PS_PARAM && gacp_pkg::is_digit(cbuf.data)) begin
                num_nxt = DW'(num_r * gacp_pkg::DEC_BASE + DW'(cbuf.data - gacp_pkg::CHR_0));
                dig_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ps_r <= gacp_pkg::PS_LETTER;
            let_r <= 8'h00;
            num_r <= '0;
            dig_r <= 1'b0;
            exec_r <= 1'b0;
            pd_r <= '0;
        end else begin
            ps_r <= ps_nxt;
            let_r <= let_nxt;
            num_r <= num_nxt;
            dig_r <= dig_nxt;
            exec_r <= exec_nxt;
            pd_r <= pd_nxt;
        end
    end

    // operating modes
    logic [2:0] disp_r, disp_nxt, trig_r, trig_nxt;
    logic [1:0] prog_r, prog_nxt;
    logic [DW-1:0] dwell_r, dwell_nxt;
    logic [LW-1:0] bptr_r, bptr_nxt, dptr_r, dptr_nxt;
    logic run_r, run_nxt, err_r, err_nxt, mclr_r, mclr_nxt;

    always_comb begin
        disp_nxt = disp_r;
        prog_nxt = prog_r;
        trig_nxt = trig_r;
        dwell_nxt = dwell_r;
        bptr_nxt = bptr_r;
        dptr_nxt = dptr_r;
        run_nxt = run_r;
        err_nxt = err_r;
        mclr_nxt = 1'b0;
        if (clr) begin
            disp_nxt = gacp_pkg::DISP_DEF;
            prog_nxt = gacp_pkg::PROG_DEF;
            trig_nxt = gacp_pkg::TRIG_DEF;
            dwell_nxt = gacp_pkg::DWELL_DEF;
            run_nxt = 1'b0;
            bptr_nxt = gacp_pkg::LOC_FIRST;
            dptr_nxt = gacp_pkg::LOC_FIRST;
            mclr_nxt = 1'b1;
            // an error reported in the same cycle survives the clear
            err_nxt = exec_r && pd_r.err;
        end else begin
            if (exec_r) begin
                if (pd_r.err) begin
                    err_nxt = 1'b1;
                end else begin
                    err_nxt = 1'b0;
                    // display, then program mode, then trigger, dwell, location
                    if (pd_r.d_v) begin
                        disp_nxt = pd_r.d;
                    end
                    if (pd_r.p_v) begin
                        prog_nxt = pd_r.p;
                    end
                    if (pd_r.t_v) begin
                        trig_nxt = pd_r.t;
                    end
                    if (pd_r.w_v) begin
                        dwell_nxt = pd_r.w;
                    end
                    if (pd_r.b_v) begin
                        bptr_nxt = pd_r.b;
                        dptr_nxt = pd_r.b;
                    end
                end
            end
            // group trigger needs no addressing
            if (get_cmd) begin
                if (trig_r == gacp_pkg::TRIG_START_GET) begin
                    run_nxt = 1'b1;
                end else if (trig_r == gacp_pkg::TRIG_STOP_GET) begin
                    run_nxt = 1'b0;
                end
                // any other trigger mode keeps run_r as it is
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            disp_r <= gacp_pkg::DISP_DEF;
            prog_r <= gacp_pkg::PROG_DEF;
            trig_r <= gacp_pkg::TRIG_DEF;
            dwell_r <= gacp_pkg::DWELL_DEF;
            bptr_r <= gacp_pkg::LOC_FIRST;
            dptr_r <= gacp_pkg::LOC_FIRST;
            run_r <= 1'b0;
            err_r <= 1'b0;
            mclr_r <= 1'b0;
        end else begin
            disp_r <= disp_nxt;
            prog_r <= prog_nxt;
            trig_r <= trig_nxt;
            dwell_r <= dwell_nxt;
            bptr_r <= bptr_nxt;
            dptr_r <= dptr_nxt;
            run_r <= run_nxt;
            err_r <= err_nxt;
            mclr_r <= mclr_nxt;
        end
    end

    assign disp_mode = disp_r;
    assign prog_mode = prog_r;
    assign trig_mode = trig_r;
    assign dwell_time = dwell_r;
    assign buf_ptr = bptr_r;
    assign disp_ptr = dptr_r;
    assign mem_clear = mclr_r;
    assign running_led = run_r;

    always_comb begin
        status_word = '0;
        status_word[gacp_pkg::ST_DISP_LSB +: 3] = disp_r;
        status_word[gacp_pkg::ST_PROG_LSB +: 2] = prog_r;
        status_word[gacp_pkg::ST_TRIG_LSB +: 3] = trig_r;
        status_word[gacp_pkg::ST_RUN_BIT] = run_r;
        status_word[gacp_pkg::ST_REM_BIT] = remote_led;
        status_word[gacp_pkg::ST_LLO_BIT] = lockout;
        status_word[gacp_pkg::ST_ERR_BIT] = err_r;
    end

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_sdc_addr_gate: assert property (sdc_cmd && !listen_r |=> !mem_clear) else $error("unaddressed clear acted");
    a_sdc_defaults: assert property (sdc_cmd && listen_r |=> disp_mode == gacp_pkg::DISP_DEF
        && trig_mode == gacp_pkg::TRIG_DEF && prog_mode == gacp_pkg::PROG_DEF && !running_led)
        else $error("selective clear left modes");
    a_clear_ptrs: assert property (clr |=> mem_clear && buf_ptr == gacp_pkg::LOC_FIRST
        && disp_ptr == gacp_pkg::LOC_FIRST ##1 (!mem_clear || $past(clr)))
        else $error("clear pointers or erase wrong");
    a_dcl_erase: assert property (dcl_cmd |=> mem_clear) else $error("universal clear kept memory");
    a_get_start: assert property (get_cmd && trig_r == gacp_pkg::TRIG_START_GET |=> running_led)
        else $error("start trigger ignored");
    a_get_unaddr: assert property (get_cmd && !listen_r && trig_r == gacp_pkg::TRIG_START_GET
        |=> running_led && !$past(listen_r)) else $error("unaddressed trigger ignored");
    a_get_stop: assert property (get_cmd && trig_r == gacp_pkg::TRIG_STOP_GET |=> !running_led)
        else $error("stop trigger ignored");
    a_run_cause: assert property ($rose(running_led) |-> $past(get_cmd)
        && $past(trig_r) == gacp_pkg::TRIG_START_GET) else $error("indicator rose without trigger");
    a_get_other: assert property (get_cmd && trig_r != gacp_pkg::TRIG_START_GET
        && trig_r != gacp_pkg::TRIG_STOP_GET |=> $stable(running_led)) else $error("trigger moved run");
    a_gtl_local: assert property (gtl_cmd && listen_r |=> !remote_led) else $error("go-to-local ignored");
    a_llo_release: assert property ($fell(lockout) |-> $past(!ren)) else $error("lockout left with ren");
    a_ren_drop: assert property (!ren |=> !remote_led && !lockout) else $error("ren low kept remote");
    a_panel_lock: assert property (lockout |-> !panel_grant) else $error("panel used under lockout");
    a_local_key: assert property (local_key |=> !remote_led) else $error("local key ignored");
    a_data_only: assert property (fifo_in_valid |-> !bus_atn && listen_r) else $error("command byte buffered");
    a_hold_till_x: assert property (!exec_r && !clr |=> $stable(disp_mode) && $stable(prog_mode)
        && $stable(dwell_time)) else $error("mode changed before execute");
    a_exec_after_x: assert property (take && cbuf.data == gacp_pkg::LET_EXEC && !clr |=> exec_r ##1 !exec_r)
        else $error("execute not one cycle");
    a_illegal_keep: assert property (exec_r && pd_r.err && !clr |=> $stable(disp_mode) && $stable(trig_mode)
        && status_word[gacp_pkg::ST_ERR_BIT]) else $error("illegal command changed mode");
    a_status_trig: assert property (exec_r && !pd_r.err && pd_r.t_v && !clr
        |=> status_word[gacp_pkg::ST_TRIG_LSB +: 3] == $past(pd_r.t)) else $error("status not updated");
    a_letter_param: assert property (take && ps_r == gacp_pkg::PS_LETTER && !gacp_pkg::is_upper(cbuf.data)
        && !clr |=> ps_r == gacp_pkg::PS_LETTER) else $error("parameter without letter");

    c_sdc_hit: cover property (sdc_cmd && listen_r);
    c_get_start: cover property (get_cmd && trig_r == gacp_pkg::TRIG_START_GET ##1 running_led);
    c_exec_ok: cover property (exec_r && !pd_r.err && pd_r.d_v && pd_r.p_v);
    c_backpress: cover property (bus_valid && !bus_ready);
endmodule
`default_nettype wire

// ---- testbench/gacp_ctl_model.sv ----
// bus controller model handing command and data bytes to the handler
`timescale 1ns/1ns
`default_nettype none
module gacp_ctl_model (
    // bus
    input wire logic mclk,
    input wire logic bus_ready,
    output logic bus_valid,
    output logic bus_atn,
    output logic [7:0] bus_data
);
    initial begin
        bus_valid = 1'b0;
        bus_atn = 1'b0;
        bus_data = 8'h00;
    end
    // byte held until ready is seen at an edge
    task automatic send(input logic a, input logic [7:0] d);
        bus_valid <= 1'b1;
        bus_atn <= a;
        bus_data <= d;
        do @(posedge mclk); while (bus_ready !== 1'b1);
    endtask
    // released lines show no stale byte
    task automatic idle();
        bus_valid <= 1'b0;
        bus_data <= ~bus_data;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- testbench/gacp_top_tb.sv ----
// self-checking bench for the command handler
`timescale 1ns/1ns
`default_nettype none
module gacp_top_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] my_addr = 5'h0b;
    logic ren = 1'b0;
    logic local_key = 1'b0;
    logic panel_req = 1'b0;
    logic bus_valid, bus_atn, bus_ready, panel_grant, remote_led, lockout, running_led, mem_clear;
    logic [7:0] bus_data, buf_ptr, disp_ptr;
    logic [2:0] disp_mode, trig_mode;
    logic [1:0] prog_mode;
    logic [15:0] dwell_time, status_word;
    int n_fail = 0;
    int checked = 0;
    int n_clr = 0;
    gacp_top dut_u (.*);
    gacp_ctl_model ctl_u (.*);
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (mem_clear === 1'b1) n_clr <= n_clr + 1;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one bus command, optionally after the listen address
    task automatic cmd(input logic lis, input logic [4:0] a, input logic [7:0] c);
        if (lis) ctl_u.send(1'b1, {3'h1, a});
        ctl_u.send(1'b1, c);
        ctl_u.idle();
        repeat (2) @(posedge mclk);
    endtask
    // listen, send text, let the parser finish
    task automatic prog(input logic [4:0] a, input string s);
        ctl_u.send(1'b1, {3'h1, a});
        foreach (s[i]) ctl_u.send(1'b0, s[i]);
        ctl_u.idle();
        repeat (10) @(posedge mclk);
    endtask
    task automatic t_addr();
        ren <= 1'b1;
        prog(my_addr ^ 5'h01, "T2X");
        cmd(1'b0, 5'h00, gacp_pkg::CMD_SDC);
        chk("trig", {13'h0000, trig_mode}, 16'h0006);
        chk("remote", {15'h0000, remote_led}, 16'h0000);
        chk("clr", 16'(n_clr), 16'h0000);
    endtask
    task automatic t_buffer();
        prog(my_addr, "P2T2W35");
        chk("trig", {13'h0000, trig_mode}, 16'h0006);
        chk("dwell", dwell_time, 16'h0000);
        prog(my_addr, "X");
        chk("status", status_word, 16'h0250);
        chk("dwell", dwell_time, 16'h0023);
    endtask
    task automatic t_trig();
        cmd(1'b0, 5'h00, gacp_pkg::CMD_UNL);
        cmd(1'b0, 5'h00, gacp_pkg::CMD_GET);
        chk("run", {15'h0000, running_led}, 16'h0001);
        prog(my_addr, "T3X");
        cmd(1'b0, 5'h00, gacp_pkg::CMD_GET);
        chk("run", {15'h0000, running_led}, 16'h0000);
        prog(my_addr, "T2X");
        cmd(1'b0, 5'h00, gacp_pkg::CMD_GET);
        prog(my_addr, "T5X");
        cmd(1'b0, 5'h00, gacp_pkg::CMD_GET);
        chk("run", {15'h0000, running_led}, 16'h0001);
        prog(my_addr, "Q1X");
        chk("trig", {13'h0000, trig_mode}, 16'h0005);
        chk("err", {15'h0000, status_word[11]}, 16'h0001);
    endtask
    task automatic t_clear();
        prog(my_addr, "B5D1X");
        chk("ptr", {8'h00, buf_ptr}, 16'h0005);
        cmd(1'b1, my_addr, gacp_pkg::CMD_SDC);
        chk("clr", 16'(n_clr), 16'h0001);
        chk("ptrs", {buf_ptr, disp_ptr}, 16'h0101);
        chk("modes", {9'h000, disp_mode, trig_mode, running_led}, 16'h000c);
        cmd(1'b0, 5'h00, gacp_pkg::CMD_DCL);
        chk("clr", 16'(n_clr), 16'h0002);
    endtask
    task automatic t_remote();
        panel_req <= 1'b1;
        cmd(1'b1, my_addr, gacp_pkg::CMD_LLO);
        chk("grant", {15'h0000, panel_grant}, 16'h0000);
        cmd(1'b0, 5'h00, gacp_pkg::CMD_GTL);
        chk("rl", {14'h0000, remote_led, lockout}, 16'h0001);
        ren <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("grant", {14'h0000, lockout, panel_grant}, 16'h0001);
        ren <= 1'b1;
        cmd(1'b1, my_addr, gacp_pkg::CMD_UNL);
        local_key <= 1'b1;
        @(posedge mclk);
        local_key <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("remote", {15'h0000, remote_led}, 16'h0000);
    endtask
    // hang guard, far above the expected run
    initial begin
        #40000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("status", status_word, 16'h00c0);
        t_addr();
        t_buffer();
        t_trig();
        t_clear();
        t_remote();
        conclude();
    end
endmodule
`default_nettype wire
